/* hw/pcrs_top.sv */
// Program counter with latches, vectors and hardware return stack
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
// How it works
// - Program counter is 21 bits wide.
// - Fetch above built memory returns zero.
// - Built program memory is 16 Kbytes.
// - Reset at 0000h, vectors 0008h, 0018h.
// - Only low byte reachable by software.
// - Low byte write loads both latches.
// - Low byte read copies upper bytes out.
// - Bit zero stays zero; step by two.
// - Calls and gotos bypass the latches.
// - Calls and interrupts push, 31 deep.
// - Returns of all kinds pop.
// - Calls and returns leave latches alone unless a fault reset clears them.
// - Separate 31 by 21 array, 5-bit pointer.
// - Software reads, writes pointer and top.
// - Push bumps pointer, then writes entry.
// - Pop reads entry, then drops pointer.
// - Reset clears pointer; zero means empty.
// - Flags report full and underflow.
// - Enabled wake interrupt pushes and vectors.
// - 31st push sets full; reset or hold.
// - Empty pop loads zero, sets underflow.
// - Flags stay until software or power-on.
// - Pointer register: full, underflow, zero, pointer.
module pcrs_top
    import pcrs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Core sequencing request
    input pcrs_op_t coreOp,
    input wire logic [20:0] opTarget,
    input wire logic irqHighPri,
    // Interrupt enables and configuration
    input wire logic highPriorityGlobalIrqEnable,
    input wire logic lowPriorityGlobalIrqEnable,
    input wire logic stackFaultResetEnable,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata_q,
    // Program memory fetch
    output logic [20:0] fetchAddr,
    input wire logic [15:0] progData,
    output logic [15:0] instrWord_q,
    // Stack state and fault reset request
    output logic stackFullFlag,
    output logic stackUnderflowFlag,
    output logic [4:0] pointerValueField,
    output logic stackFaultReset_q
);
    // ========================================
    // State
    // 21-bit counter, three bytes
    logic [20:0] pc_q;
    logic [20:0] pc_d;
    // Latches feeding high and upper bytes
    logic [7:0] pcHighLatch_q;
    logic [7:0] pcHighLatch_d;
    logic [4:0] pcUpperLatch_q;
    logic [4:0] pcUpperLatch_d;
    // Stack pointer and sticky flags
    logic [4:0] sp_q;
    logic [4:0] sp_d;
    logic full_q;
    logic unf_q;
    // Fault reset pulse next value
    logic fault_d;

    // ========================================
    // Stack array signals
    logic ramWe;
    logic [4:0] ramWaddr;
    logic [20:0] ramWdata;
    logic [20:0] tosWord;

    // ========================================
    // Decode helpers
    logic wrPcLow;
    logic wrSp;
    logic wrTos;
    logic rdPcLow;
    logic irqEnabled;
    logic setFull;
    logic setUnf;
    logic doPush;
    logic doPop;
    logic [20:0] pushVal;
    logic [20:0] pushDest;
    logic [4:0] spInc;

    // Register strobes
    assign wrPcLow = regWr && regAddr == ADDR_PC_LOW;
    assign wrSp = regWr && regAddr == ADDR_STACK_POINTER;
    assign wrTos = regWr && (regAddr == ADDR_TOS_LOW
        || regAddr == ADDR_TOS_HIGH || regAddr == ADDR_TOS_UPPER);
    assign rdPcLow = regRd && regAddr == ADDR_PC_LOW;

    // either global enable accepts the wake
    assign irqEnabled = highPriorityGlobalIrqEnable || lowPriorityGlobalIrqEnable;

    assign spInc = sp_q + SP_ONE;

    // ========================================
    // Stack storage
    // dedicated array, outside both spaces
    pcrs_stack_ram uStack (
        .clk(clk),
        .wrEn(ramWe),
        .wrIdx(ramWaddr),
        .wrData(ramWdata),
        .rdIdx(sp_q),
        .rdData(tosWord)
    );

    // ========================================
    // Fetch path
    assign fetchAddr = pc_q;

    pcrs_fetch_guard uGuard (
        .clk(clk),
        .rstn(rstn),
        .fetchAddr(pc_q),
        .progData(progData),
        .instrWord_q(instrWord_q)
    );

    // ========================================
    // Operation decode
    // calls and interrupts push
    always_comb begin
        doPush = 1'b0;
        doPop = 1'b0;
        pushVal = pc_q;
        pushDest = pc_q;
        case (coreOp)
            OP_CALL: begin
                // saved value already points past the call
                doPush = 1'b1;
                pushVal = pc_q + PC_STEP;
                pushDest = {opTarget[20:1], 1'b0};
            end
            OP_IRQ: begin
                // current counter is the next unexecuted word
                doPush = irqEnabled;
                pushVal = pc_q;
                pushDest = irqHighPri ? VEC_HIGH : VEC_LOW;
            end
            OP_RET: begin
                // all return kinds share the pop
                doPop = 1'b1;
            end
            default: begin
                // No stack traffic
                doPush = 1'b0;
            end
        endcase
    end

    // ========================================
    // Next state of counter, pointer and array
    // Core operation first; a software pointer write overrides it, a fault reset overrides both
    always_comb begin
        pc_d = pc_q;
        sp_d = sp_q;
        ramWe = 1'b0;
        ramWaddr = sp_q;
        ramWdata = tosWord;
        setFull = 1'b0;
        setUnf = 1'b0;
        fault_d = 1'b0;
        case (coreOp)
            OP_STEP: begin
                pc_d = pc_q + PC_STEP;
            end
            OP_JUMP: begin
                pc_d = {opTarget[20:1], 1'b0};
            end
            default: begin
                pc_d = pc_q;
            end
        endcase
        if (doPush) begin
            pc_d = pushDest;
            if (sp_q == SP_FULL) begin
                // already full, last entry kept intact
                setFull = 1'b1;
            end else begin
                sp_d = spInc;
                ramWe = 1'b1;
                ramWaddr = spInc;
                ramWdata = pushVal;
                setFull = spInc == SP_FULL;
            end
            if (setFull && stackFaultResetEnable) begin
                fault_d = 1'b1;
            end
        end else if (doPop) begin
            if (sp_q == SP_EMPTY) begin
                // empty pop returns zero, pointer stays
                pc_d = RESET_VEC;
                setUnf = 1'b1;
                fault_d = stackFaultResetEnable;
            end else begin
                // take top first, then drop pointer
                pc_d = tosWord;
                sp_d = sp_q - SP_ONE;
            end
        end
        // low byte write pulls both latches in
        if (wrPcLow) begin
            pc_d = {pcUpperLatch_q, pcHighLatch_q, regWdata[7:1], 1'b0};
        end
        if (wrSp) begin
            sp_d = regWdata[4:0];
        end
        // software edits one byte of the top entry
        if (wrTos && !ramWe && sp_q != SP_EMPTY) begin
            ramWe = 1'b1;
            ramWaddr = sp_q;
            ramWdata = tosWord;
            case (regAddr)
                ADDR_TOS_LOW: ramWdata[7:0] = regWdata;
                ADDR_TOS_HIGH: ramWdata[15:8] = regWdata;
                default: ramWdata[20:16] = regWdata[4:0];
            endcase
        end
        // fault reset returns to the start, pointer empty
        if (fault_d) begin
            pc_d = RESET_VEC;
            sp_d = SP_EMPTY;
        end
    end

    // ========================================
    // Program counter register
    // execution starts at the reset vector
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_q <= RESET_VEC;
        end else begin
            // bit zero forced low on every load
            pc_q <= {pc_d[20:1], 1'b0};
        end
    end

    // ========================================
    // Latch registers
    // Next latch values from software access
    always_comb begin
        pcHighLatch_d = pcHighLatch_q;
        pcUpperLatch_d = pcUpperLatch_q;
        if (fault_d) begin
            // Device reset clears them too
            pcHighLatch_d = REG_RESET;
            pcUpperLatch_d = REG_RESET[4:0];
        end else if (rdPcLow) begin
            // reading the low byte snapshots upper bytes
            pcHighLatch_d = pc_q[15:8];
            pcUpperLatch_d = pc_q[20:16];
        end else if (regWr && regAddr == ADDR_PC_HIGH_LATCH) begin
            pcHighLatch_d = regWdata;
        end else if (regWr && regAddr == ADDR_PC_UPPER_LATCH) begin
            pcUpperLatch_d = regWdata[4:0];
        end
    end

    // only software access and the fault reset above change the latches
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pcHighLatch_q <= REG_RESET;
            pcUpperLatch_q <= REG_RESET[4:0];
        end else begin
            pcHighLatch_q <= pcHighLatch_d;
            pcUpperLatch_q <= pcUpperLatch_d;
        end
    end

    // ========================================
    // Stack pointer
    // every reset empties the stack
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sp_q <= SP_EMPTY;
        end else begin
            sp_q <= sp_d;
        end
    end

    // ========================================
    // Sticky flags
    // Writing a zero clears a flag; a new event in that cycle wins,
    // so software never loses an overflow it did not see
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            full_q <= 1'b0;
            unf_q <= 1'b0;
        end else begin
            // survives fault reset, cleared by software or power-on reset only
            full_q <= setFull || (full_q && !(wrSp && !regWdata[FULL_BIT]));
            unf_q <= setUnf || (unf_q && !(wrSp && !regWdata[UNF_BIT]));
        end
    end

    // ========================================
    // Fault reset request, one-cycle pulse
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stackFaultReset_q <= 1'b0;
        end else begin
            stackFaultReset_q <= fault_d;
        end
    end

    // ========================================
    // Read data, one cycle after the strobe
    // high and upper bytes have no direct read path
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdata_q <= REG_RESET;
        end else if (regRd) begin
            case (regAddr)
                ADDR_PC_LOW: regRdata_q <= pc_q[7:0];
                ADDR_PC_HIGH_LATCH: regRdata_q <= pcHighLatch_q;
                ADDR_PC_UPPER_LATCH: regRdata_q <= {3'h0, pcUpperLatch_q};
                ADDR_STACK_POINTER: regRdata_q <= {full_q, unf_q, 1'b0, sp_q};
                // top entry bytes, zero when empty
                ADDR_TOS_LOW: regRdata_q <= tosWord[7:0];
                ADDR_TOS_HIGH: regRdata_q <= tosWord[15:8];
                ADDR_TOS_UPPER: regRdata_q <= {3'h0, tosWord[20:16]};
                default: regRdata_q <= UNMAPPED_READ;
            endcase
        end else begin
            // Data stand only in the cycle after the read
            regRdata_q <= REG_RESET;
        end
    end

    // ========================================
    // Status outputs
    assign stackFullFlag = full_q;
    assign stackUnderflowFlag = unf_q;
    assign pointerValueField = sp_q;

endmodule

/* hw/pcrs_pkg.sv */
// Shared constants and types of the program counter and return stack
package pcrs_pkg;

    // ========================================
    // Widths and sizes
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int STACK_DEPTH = 31;
    localparam int PROG_BYTES = 16384;
    localparam int PROG_WORDS = 8192;
    localparam int REG_AW = 4;

    // ========================================
    // Vectors and stepping
    localparam logic [20:0] RESET_VEC = 21'h000000;
    localparam logic [20:0] VEC_HIGH = 21'h000008;
    localparam logic [20:0] VEC_LOW = 21'h000018;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [20:0] PROG_LIMIT = 21'h004000;
    localparam logic [4:0] SP_EMPTY = 5'h00;
    localparam logic [4:0] SP_FULL = 5'h1f;
    localparam logic [4:0] SP_ONE = 5'h01;

    // ========================================
    // Register map, one byte per index
    localparam logic [3:0] ADDR_PC_LOW = 4'h0;
    localparam logic [3:0] ADDR_PC_HIGH_LATCH = 4'h1;
    localparam logic [3:0] ADDR_PC_UPPER_LATCH = 4'h2;
    localparam logic [3:0] ADDR_STACK_POINTER = 4'h3;
    localparam logic [3:0] ADDR_TOS_LOW = 4'h4;
    localparam logic [3:0] ADDR_TOS_HIGH = 4'h5;
    localparam logic [3:0] ADDR_TOS_UPPER = 4'h6;

    // ========================================
    // Pointer register fields and reset values
    localparam int FULL_BIT = 7;
    localparam int UNF_BIT = 6;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ========================================
    // Sequencing operations requested by the core
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_STEP = 3'h1,
        OP_JUMP = 3'h3,
        OP_CALL = 3'h2,
        OP_RET = 3'h6,
        OP_IRQ = 3'h7
    } pcrs_op_t;

endpackage

/* hw/pcrs_stack_ram.sv */
// Return address storage, 31 entries of 21 bits
`timescale 1ns/1ns
module pcrs_stack_ram
    import pcrs_pkg::*;
(
    // Clock
    input wire logic clk,
    // Write port
    input wire logic wrEn,
    input wire logic [4:0] wrIdx,
    input wire logic [20:0] wrData,
    // Read port, combinational
    input wire logic [4:0] rdIdx,
    output logic [20:0] rdData
);
    // ========================================
    // Storage; index zero has no entry behind it
    logic [20:0] mem [1:STACK_DEPTH];

    // Write only to real entries
    always_ff @(posedge clk) begin
        if (wrEn && wrIdx != SP_EMPTY) begin
            mem[wrIdx] <= wrData;
        end
    end

    // Empty index reads as zero
    always_comb begin
        if (rdIdx == SP_EMPTY) begin
            rdData = RESET_VEC;
        end else begin
            rdData = mem[rdIdx];
        end
    end
endmodule

/* hw/pcrs_fetch_guard.sv */
// Fetch window check that turns unbuilt program space into zero words
`timescale 1ns/1ns
module pcrs_fetch_guard
    import pcrs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Fetch address and raw memory word
    input wire logic [20:0] fetchAddr,
    input wire logic [15:0] progData,
    // Guarded instruction word
    output logic [15:0] instrWord_q
);
    // ========================================
    // Only the low 16 Kbytes hold real memory
    logic inRange;

    assign inRange = fetchAddr < PROG_LIMIT;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            instrWord_q <= 16'h0000;
        end else if (inRange) begin
            instrWord_q <= progData;
        end else begin
            instrWord_q <= 16'h0000;
        end
    end
endmodule

/* tb/pcrs_prog_model.sv */
// Program memory stand-in that answers each fetch address with a known word
`timescale 1ns/1ns
module pcrs_prog_model (
    // Fetch address from the counter
    input wire logic [20:0] fetchAddr,
    // Word for that address
    output logic [15:0] progData
);
    // ========================================
    // Memory contents
    // Answers past the built range too, so only the guard can zero those fetches
    assign progData = fetchAddr[16:1] ^ 16'h5a5a;
endmodule

/* tb/pcrs_top_asserts.sv */
// Concurrent checks on the ports of the program counter and return stack
`timescale 1ns/1ns
module pcrs_top_asserts
    import pcrs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Core request
    input pcrs_op_t coreOp,
    input wire logic [20:0] opTarget,
    input wire logic irqHighPri,
    input wire logic highPriorityGlobalIrqEnable,
    input wire logic lowPriorityGlobalIrqEnable,
    input wire logic stackFaultResetEnable,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata_q,
    // Fetch and stack state
    input wire logic [20:0] fetchAddr,
    input wire logic [15:0] instrWord_q,
    input wire logic stackFullFlag,
    input wire logic stackUnderflowFlag,
    input wire logic [4:0] pointerValueField,
    input wire logic stackFaultReset_q
);
    // ========================================
    // Common timing
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Software writes may override the counter, so most checks skip those cycles
    logic quiet;
    assign quiet = !regWr;
    // Headroom below full, so no push reaches the fault path
    logic roomy;
    assign roomy = pointerValueField < 5'h1e;

    // ========================================
    // Checks
    // read data only after a read
    rdata_idle_a: assert property (regRdata_q != 8'h00 |-> $past(regRd))
        else $error("read data without read");
    step_two_a: assert property (quiet && coreOp == OP_STEP |=>
        fetchAddr == $past(fetchAddr) + PC_STEP) else $error("step is not two");
    call_push_a: assert property (quiet && roomy && coreOp == OP_CALL |=>
        pointerValueField == $past(pointerValueField) + SP_ONE &&
        fetchAddr == ($past(opTarget) & 21'h1ffffe)) else $error("call push wrong");
    irq_vector_a: assert property (quiet && roomy && coreOp == OP_IRQ &&
        (highPriorityGlobalIrqEnable || lowPriorityGlobalIrqEnable) |=>
        fetchAddr == ($past(irqHighPri) ? VEC_HIGH : VEC_LOW)) else $error("bad vector");
    empty_pop_a: assert property (quiet && coreOp == OP_RET && pointerValueField == SP_EMPTY
        |=> stackUnderflowFlag && fetchAddr == RESET_VEC && pointerValueField == SP_EMPTY)
        else $error("empty pop wrong");
    full_set_a: assert property (quiet && coreOp == OP_CALL && pointerValueField == 5'h1e
        |=> stackFullFlag) else $error("full not set");
    flag_hold_a: assert property (stackFullFlag &&
        !(regWr && regAddr == ADDR_STACK_POINTER) |=> stackFullFlag) else $error("full lost");
    fault_pulse_a: assert property (stackFaultResetEnable && quiet && coreOp == OP_RET &&
        pointerValueField == SP_EMPTY |=> ##[0:1] stackFaultReset_q)
        else $error("no fault pulse");
    fetch_zero_a: assert property (fetchAddr >= PROG_LIMIT |=> instrWord_q == 16'h0000)
        else $error("unbuilt fetch not zero");
endmodule
bind pcrs_top pcrs_top_asserts u_chk (.clk(clk), .rstn(rstn), .coreOp(coreOp),
    .opTarget(opTarget), .irqHighPri(irqHighPri),
    .highPriorityGlobalIrqEnable(highPriorityGlobalIrqEnable),
    .lowPriorityGlobalIrqEnable(lowPriorityGlobalIrqEnable),
    .stackFaultResetEnable(stackFaultResetEnable), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regRdata_q(regRdata_q), .fetchAddr(fetchAddr),
    .instrWord_q(instrWord_q), .stackFullFlag(stackFullFlag),
    .stackUnderflowFlag(stackUnderflowFlag), .pointerValueField(pointerValueField),
    .stackFaultReset_q(stackFaultReset_q));

/* tb/tb_top.sv */
// Self-checking bench for the program counter and return stack
`timescale 1ns/1ns
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", nm, e, s); end end
module tb_top;
    import pcrs_pkg::*;
    // ========================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rstn = 1'b0;
    pcrs_op_t coreOp = OP_NONE;
    logic [20:0] opTarget = 21'h0;
    logic irqHighPri = 1'b0;
    logic hiEn = 1'b1;
    logic loEn = 1'b0;
    logic faultEn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata_q;
    logic [20:0] fetchAddr;
    logic [15:0] progData;
    logic [15:0] instrWord_q;
    logic fullFlag;
    logic unfFlag;
    logic faultPulse;
    logic faultSeen = 1'b0;
    logic [4:0] ptr;
    int error_cnt = 0;
    int check_count = 0;
    // One core request and the counter and pointer it should leave
    typedef struct {pcrs_op_t op; logic [20:0] tgt; logic hi; logic [20:0] pc;
        logic [4:0] sp;} pcrs_row_t;
    pcrs_row_t rows [11] = '{'{OP_STEP, 21'h0, 1'b0, 21'h000002, 5'h00},
        '{OP_STEP, 21'h0, 1'b0, 21'h000004, 5'h00},
        '{OP_CALL, 21'h001234, 1'b0, 21'h001234, 5'h01},
        '{OP_JUMP, 21'h1f0001, 1'b0, 21'h1f0000, 5'h01},
        '{OP_IRQ, 21'h0, 1'b1, 21'h000008, 5'h02},
        '{OP_IRQ, 21'h0, 1'b0, 21'h000018, 5'h03},
        '{OP_NONE, 21'h0, 1'b0, 21'h000018, 5'h03},
        '{OP_RET, 21'h0, 1'b0, 21'h000008, 5'h02},
        '{OP_RET, 21'h0, 1'b0, 21'h1f0000, 5'h01},
        '{OP_RET, 21'h0, 1'b0, 21'h000006, 5'h00},
        '{OP_RET, 21'h0, 1'b0, 21'h000000, 5'h00}};

    // ========================================
    // Clock, device and far side
    always #5 clk = ~clk;
    pcrs_top i_dut (.clk(clk), .rstn(rstn), .coreOp(coreOp), .opTarget(opTarget),
        .irqHighPri(irqHighPri), .highPriorityGlobalIrqEnable(hiEn),
        .lowPriorityGlobalIrqEnable(loEn), .stackFaultResetEnable(faultEn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata_q(regRdata_q), .fetchAddr(fetchAddr), .progData(progData),
        .instrWord_q(instrWord_q), .stackFullFlag(fullFlag), .stackUnderflowFlag(unfFlag),
        .pointerValueField(ptr), .stackFaultReset_q(faultPulse));
    pcrs_prog_model i_mem (.fetchAddr(fetchAddr), .progData(progData));
    // The pulse lasts one cycle, so latch it for a later look
    always @(posedge clk) if (faultPulse) faultSeen <= 1'b1;

    // ========================================
    // Bus and core tasks
    task automatic op(pcrs_op_t o, logic [20:0] t, logic h);
        @(posedge clk);
        coreOp <= o;
        opTarget <= t;
        irqHighPri <= h;
        @(posedge clk);
        coreOp <= OP_NONE;
        #1;
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [3:0] a, logic [7:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        `CHK("regRdata", e, regRdata_q)
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ========================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        `CHK("pc", RESET_VEC, fetchAddr)
        rd(ADDR_STACK_POINTER, 8'h00);
        foreach (rows[i]) begin
            op(rows[i].op, rows[i].tgt, rows[i].hi);
            `CHK("pc", rows[i].pc, fetchAddr)
            `CHK("sp", rows[i].sp, ptr)
        end
        rd(ADDR_STACK_POINTER, 8'h40);
        `CHK("unf", 1'b1, unfFlag)
        // Latched upper bytes enter only through a low byte write
        wr(ADDR_PC_HIGH_LATCH, 8'h12);
        wr(ADDR_PC_UPPER_LATCH, 8'h03);
        wr(ADDR_PC_LOW, 8'h57);
        `CHK("pc", 21'h031256, fetchAddr)
        op(OP_CALL, 21'h000200, 1'b0);
        `CHK("pc", 21'h000200, fetchAddr)
        op(OP_RET, 21'h0, 1'b0);
        `CHK("pc", 21'h031258, fetchAddr)
        rd(ADDR_PC_HIGH_LATCH, 8'h12);
        op(OP_JUMP, 21'h05ab00, 1'b0);
        rd(ADDR_PC_LOW, 8'h00);
        rd(ADDR_PC_HIGH_LATCH, 8'hab);
        rd(ADDR_PC_UPPER_LATCH, 8'h05);
        // Top entry seen and edited by software
        op(OP_CALL, 21'h000100, 1'b0);
        rd(ADDR_TOS_LOW, 8'h02);
        rd(ADDR_TOS_HIGH, 8'hab);
        rd(ADDR_TOS_UPPER, 8'h05);
        wr(ADDR_TOS_LOW, 8'h40);
        op(OP_RET, 21'h0, 1'b0);
        `CHK("pc", 21'h05ab40, fetchAddr)
        rd(4'hf, 8'h00);
        // Interrupt with both enables off does nothing
        @(posedge clk) hiEn <= 1'b0;
        op(OP_IRQ, 21'h0, 1'b1);
        `CHK("pc", 21'h05ab40, fetchAddr)
        // Low priority enable alone also takes the interrupt
        @(posedge clk) loEn <= 1'b1;
        op(OP_IRQ, 21'h0, 1'b0);
        `CHK("pc", VEC_LOW, fetchAddr)
        op(OP_RET, 21'h0, 1'b0);
        `CHK("pc", 21'h05ab40, fetchAddr)
        // Fetch guard at the edge of built memory
        op(OP_JUMP, 21'h004000, 1'b0);
        @(posedge clk);
        #1;
        `CHK("instr", 16'h0000, instrWord_q)
        op(OP_JUMP, 21'h003ffe, 1'b0);
        @(posedge clk);
        #1;
        `CHK("instr", 16'h1fff ^ 16'h5a5a, instrWord_q)
        // Fill the stack, then one more push after a jump
        wr(ADDR_STACK_POINTER, 8'h00);
        rd(ADDR_STACK_POINTER, 8'h00);
        repeat (31) op(OP_CALL, 21'h000300, 1'b0);
        op(OP_JUMP, 21'h000700, 1'b0);
        op(OP_CALL, 21'h000300, 1'b0);
        rd(ADDR_STACK_POINTER, 8'h9f);
        `CHK("full", 1'b1, fullFlag)
        rd(ADDR_TOS_LOW, 8'h02);
        rd(ADDR_TOS_HIGH, 8'h03);
        // Underflow with the fault reset option on
        wr(ADDR_STACK_POINTER, 8'h00);
        @(posedge clk) faultEn <= 1'b1;
        op(OP_RET, 21'h0, 1'b0);
        @(posedge clk);
        #1;
        `CHK("fault", 1'b1, faultSeen)
        `CHK("pc", RESET_VEC, fetchAddr)
        rd(ADDR_STACK_POINTER, 8'h40);
        // Full stack with the fault reset option on
        repeat (31) op(OP_CALL, 21'h000300, 1'b0);
        `CHK("sp", 5'h00, ptr)
        `CHK("pc", RESET_VEC, fetchAddr)
        rd(ADDR_STACK_POINTER, 8'hc0);
        // Power-on reset in mid-run clears the flags
        @(posedge clk) rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        rd(ADDR_STACK_POINTER, 8'h00);
        finish_test();
    end

    // ========================================
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #20000;
        error_cnt++;
        finish_test();
    end
endmodule
